// >>> harmonic_distortion_alarm_monitor_bench.sv
`timescale 1ns/1ps
module harmonic_distortion_alarm_monitor_bench;
	import hdm_pkg::*;
	logic clk, nrst, mag, cnt_clr, want_blk, tick, block_in, blocked_o;
	logic [2:0] en, start_o, alarm_o;
	logic [2:0][THD_W-1:0] pickup_set;
	logic [2:0][DLY_W-1:0] alarm_delay;
	logic [CH_N-1:0][THD_W-1:0] want, amp, pow;
	logic [GRP_W-1:0] grp;
	logic [TS_W-1:0] time_now;
	logic [EV_N-1:0] on_en, off_en;
	logic [PTR_W-1:0] rd_idx, wptr, fill;
	hdm_cond_e cond;
	hdm_evt_s events;
	hdm_cnt_s counters;
	hdm_rec_s rec;
	hdm_rec_s exp_hist[HIST_N];
	int num_errors, comparisons, nl, c_st, c_al, c_bl, nrec;
	int pu[3], st[3], al[3], bl[3], tm[3], on_n[7], off_n[7], got_on[7], got_off[7];

	hdm_front front (.clk(clk), .nrst(nrst), .want(want), .want_blk(want_blk), .tick(tick),
		.block_in(block_in), .amp(amp), .pow(pow));
	hdm_monitor dut (.clk(clk), .nrst(nrst), .tick(tick), .block_in(block_in), .mag_power(mag),
		.elem_en(en), .pickup_set(pickup_set), .alarm_delay(alarm_delay), .thd_amp(amp),
		.thd_pow(pow), .setting_group(grp), .time_now(time_now), .ev_on_en(on_en),
		.ev_off_en(off_en), .cnt_clr(cnt_clr), .rd_idx(rd_idx), .start_o(start_o),
		.alarm_o(alarm_o), .blocked_o(blocked_o), .monitor_condition(cond), .events(events),
		.counters(counters), .hist_rd(rec), .hist_wptr(wptr), .hist_fill(fill));

	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Values straddle the 10 % setting so both hysteresis edges are hit
	task automatic rnd(input logic m);
		@(posedge clk);
		for (int c = 0; c < CH_N; c++) want[c] <= THD_W'(940 + $urandom % 120);
		for (int g = 0; g < 3; g++) begin
			alarm_delay[g] <= DLY_W'($urandom % 5);
			pickup_set[g] <= THD_W'(960 + $urandom % 80);
		end
		want_blk <= $urandom % 6 == 0;
		en <= ($urandom % 8 == 0) ? 3'($urandom) : 3'h7;
		on_en <= 7'($urandom);
		off_en <= 7'($urandom);
		rd_idx <= 4'($urandom % 14);
		grp <= 3'($urandom);
		cnt_clr <= $urandom % 10 == 0;
		mag <= m;
	endtask

	// Model one program cycle, then compare once everything has settled
	task automatic tk();
		int hit, keep, ol, x;
		logic [2:0][THD_W-1:0] ph;
		logic [TS_W-1:0] ts0;
		do @(posedge clk); while (tick !== 1'b1);
		// Stamp of the clock in which the outputs move
		ts0 = time_now + 1'b1;
		cnt_clr <= 1'b0;
		if (cnt_clr) begin
			c_st = 0;
			c_al = 0;
			c_bl = 0;
		end
		ol = nl;
		nl = 0;
		for (int g = 0; g < 3; g++) begin
			hit = 0;
			keep = 0;
			for (int c = 0; c < CH_N; c++) begin
				x = mag ? pow[c] : amp[c];
				if (g == 0 && c < 3) ph[c] = THD_W'(x);
				if ((c < 3 ? 0 : c - 2) == g) begin
					hit |= x > pickup_set[g];
					keep |= x * 100 >= pickup_set[g] * 97;
				end
			end
			pu[g] = en[g] && (pu[g] ? keep : hit);
			if (!pu[g] || block_in) tm[g] = 0;
			else if (st[g]) tm[g]++;
			bl[g] = pu[g] && block_in;
			st[g] = pu[g] && !block_in;
			al[g] = st[g] && tm[g] >= alarm_delay[g];
			nl |= (st[g] << g) | (al[g] << (g + 3)) | (bl[g] << 6);
		end
		for (int b = 0; b < EV_N; b++) begin
			if (nl[b] && !ol[b]) begin
				on_n[b] += on_en[b];
				exp_hist[nrec % HIST_N] = '{ts: ts0, code: 3'(b), ph: ph, grp: grp};
				nrec++;
				if (b < 3) c_st++;
				else if (b < 6) c_al++;
				else c_bl++;
			end
			if (!nl[b] && ol[b]) off_n[b] += off_en[b];
		end
		repeat (8) @(posedge clk);
		#1;
		chk(start_o === 3'(nl), "start");
		chk(alarm_o === 3'(nl >> 3), "alarm");
		chk(blocked_o === nl[6], "blocked");
		chk(counters === {CNT_W'(c_st), CNT_W'(c_al), CNT_W'(c_bl)}, "count");
		chk(fill === PTR_W'(nrec > 12 ? 12 : nrec), "fill");
		chk(wptr === PTR_W'(nrec % 12), "wptr");
		for (int b = 0; b < EV_N; b++) begin
			chk(got_on[b] == on_n[b] && got_off[b] == off_n[b], "event");
		end
		if (rd_idx >= 12) chk(rec === '0, "read");
		else chk(rec === exp_hist[rd_idx], "record");
		if (nl <= 64) chk(cond === (nl == 0 ? COND_NORMAL : nl == 64 ? COND_BLOCKED :
			nl > 7 ? COND_ALARM : COND_START), "cond");
	endtask

	// Pulse tally; the stamp must name the clock of the output change
	always @(posedge clk) begin
		for (int b = 0; b < EV_N; b++) begin
			got_on[b] += events.on[b];
			got_off[b] += events.off[b];
		end
		if (nrst && (events.on != '0 || events.off != '0))
			chk(events.ts + 1'b1 === time_now, "stamp");
		time_now <= time_now + 1'b1;
	end

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard, well past the expected 3000 cycles
	initial begin
		#20000;
		num_errors++;
		complete_run();
	end

	initial begin
		nrst = 1'b0;
		mag = 1'b0;
		cnt_clr = 1'b0;
		want_blk = 1'b0;
		en = 3'h7;
		want = '0;
		grp = '0;
		time_now = '0;
		on_en = 7'h7f;
		off_en = 7'h7f;
		rd_idx = '0;
		pickup_set = {3{PICKUP_RST}};
		alarm_delay = '0;
		for (int i = 0; i < HIST_N; i++) exp_hist[i] = '0;
		void'($urandom(60));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		chk({start_o, alarm_o, blocked_o, cond, counters, fill, wptr} === '0, "reset");
		for (int i = 0; i < 300; i++) begin
			rnd(i >= 150);
			tk();
		end
		complete_run();
	end
endmodule // harmonic_distortion_alarm_monitor_bench

// >>> hdm_front.sv
`timescale 1ns/1ps
module hdm_front
	import hdm_pkg::*;
(
	input wire logic clk, // 200 MHz clock
	input wire logic nrst, // Async reset, low
	input wire logic [CH_N-1:0][THD_W-1:0] want, // Next values
	input wire logic want_blk, // Next block level
	output logic tick, // Program cycle pulse
	output logic block_in, // Blocking matrix level
	output logic [CH_N-1:0][THD_W-1:0] amp, // Amplitude ratio
	output logic [CH_N-1:0][THD_W-1:0] pow // Power ratio
);
	logic [3:0] div_q;

	// Values move only at a cycle start, so a block leads any expiry
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 4'h0;
			tick <= 1'b0;
			block_in <= 1'b0;
			amp <= '0;
			pow <= '0;
		end else begin
			div_q <= (div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
			tick <= div_q == 4'h9;
			if (div_q == 4'h9) begin
				block_in <= want_blk;
				amp <= want;
				for (int c = 0; c < CH_N; c++) pow[c] <= want[c] - 14'h0010;
			end
		end
	end
endmodule // hdm_front

// >>> hdm_group.sv
`timescale 1ns/1ps
module hdm_group
	import hdm_pkg::*;
#(
	parameter int N = 3
) (
	input wire logic clk, // 200 MHz clock
	input wire logic nrst, // Async reset, low
	input wire logic tick, // Program cycle pulse
	input wire logic blk, // Block level sampled this cycle
	input wire logic en, // Element enable
	input wire logic [THD_W-1:0] set, // Pick-up, 0.01 % steps
	input wire logic [DLY_W-1:0] delay, // Delay in program cycles
	input wire logic [N-1:0][THD_W-1:0] val, // Distortion per channel
	output hdm_grp_out_s q // Start, alarm, blocked
);
	hdm_grp_st_s s_q, s_d;
	logic any_over;
	logic any_keep;

	// Pick-up with hysteresis, then blocking, then definite time
	always_comb begin
		any_over = 1'b0;
		any_keep = 1'b0;
		for (int i = 0; i < N; i++) begin
			any_over = any_over | thd_over(val[i], set); // RULE_18
			any_keep = any_keep | thd_keep(val[i], set);
		end
		s_d = s_q;
		if (tick) begin // RULE_21
			s_d.pu = en && (s_q.pu ? any_keep : any_over); // RULE_16 RULE_17
			if (!s_d.pu) begin
				s_d.start = 1'b0;
				s_d.alarm = 1'b0;
				s_d.blocked = 1'b0;
				s_d.timer = '0;
			end else if (blk) begin
				// Block clears start exactly like a release would
				s_d.blocked = 1'b1; // RULE_04
				s_d.start = 1'b0; // RULE_05
				s_d.alarm = 1'b0;
				s_d.timer = '0;
			end else begin
				s_d.blocked = 1'b0;
				s_d.start = 1'b1; // RULE_03
				if (s_q.start && s_q.timer != '1)
					s_d.timer = s_q.timer + 1'b1;
				s_d.alarm = s_d.timer >= delay; // RULE_07 RULE_20
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = '{start: s_q.start, alarm: s_q.alarm, blocked: s_q.blocked};

	// Checks
	sequence s_pick;
		tick && en && !s_q.pu && any_over && !blk;
	endsequence
	property p_start;
		@(posedge clk) disable iff (!nrst) s_pick |=> s_q.start;
	endproperty
	a_start: assert property (p_start) else $error("start missing after pick-up"); // RULE_03
	property p_blk_stop;
		@(posedge clk) disable iff (!nrst) tick && blk |=> !s_q.start && !s_q.alarm;
	endproperty
	a_blk_stop: assert property (p_blk_stop) else $error("start kept while blocked"); // RULE_05
	property p_disabled;
		@(posedge clk) disable iff (!nrst) tick && !en |=> !s_q.start && !s_q.blocked;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled element active"); // RULE_17
	property p_release;
		@(posedge clk) disable iff (!nrst) tick && !any_keep |=> !s_q.start && !s_q.alarm;
	endproperty
	a_release: assert property (p_release) else $error("no release below 97 pct"); // RULE_16
	property p_alarm_time;
		@(posedge clk) disable iff (!nrst)
			$rose(s_q.alarm) |-> s_q.start && s_q.timer >= $past(delay);
	endproperty
	a_alarm_time: assert property (p_alarm_time) else $error("alarm before delay"); // RULE_20
	property p_hold;
		@(posedge clk) disable iff (!nrst) !tick |=> $stable(s_q);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved off tick"); // RULE_21
endmodule // hdm_group

// >>> hdm_monitor.sv
`timescale 1ns/1ps
// Operation
// [RULE_01] Condition shows normal, start, alarm or blocked
// [RULE_02] Block input sampled once per program cycle
// [RULE_03] Unblocked pick-up asserts start, starts timer
// [RULE_04] Blocked pick-up asserts blocked, no timing
// [RULE_05] Blocking clears active start like release
// [RULE_06] Block must arrive 5 ms before expiry
// [RULE_07] Three delays, 5 ms steps, default 10 s
// [RULE_08] Event on each output status change
// [RULE_09] Per-event ON and OFF buffer enables
// [RULE_10] Every event carries its change time stamp
// [RULE_11] Clearable start, alarm and blocked counters
// [RULE_12] Start, alarm, blocked available as binaries
// [RULE_13] Twelve newest records kept, oldest overwritten
// [RULE_14] Records made only on ON transitions
// [RULE_15] Record: time, event, phase values, group
// [RULE_16] Pick-up above setting, release below 97 %
// [RULE_17] Disabled element never picks up or alarms
// [RULE_18] Pick-up 0.01 % steps, default 10 %, any phase
// [RULE_19] Amplitude or power ratio, one static selection
// [RULE_20] Alarm after full delay; release drops both
// [RULE_21] Timers advance once per program cycle
module hdm_monitor
	import hdm_pkg::*;
(
	input wire logic clk, // 200 MHz clock
	input wire logic nrst, // Async reset, low
	input wire logic tick, // Program cycle start pulse
	input wire logic block_in, // From blocking matrix
	input wire logic mag_power, // 1 power ratio, 0 amplitude
	input wire logic [2:0] elem_en, // Phase, first, second residual
	input wire logic [2:0][THD_W-1:0] pickup_set, // Per group
	input wire logic [2:0][DLY_W-1:0] alarm_delay, // Per group
	input wire logic [CH_N-1:0][THD_W-1:0] thd_amp, // L1..L3, residuals
	input wire logic [CH_N-1:0][THD_W-1:0] thd_pow, // Same, power ratio
	input wire logic [GRP_W-1:0] setting_group, // Active group
	input wire logic [TS_W-1:0] time_now, // Wall time in ms
	input wire logic [EV_N-1:0] ev_on_en, // Buffer ON events
	input wire logic [EV_N-1:0] ev_off_en, // Buffer OFF events
	input wire logic cnt_clr, // Clear counters
	input wire logic [PTR_W-1:0] rd_idx, // History slot to read
	output logic [2:0] start_o, // Start per group
	output logic [2:0] alarm_o, // Alarm per group
	output logic blocked_o, // Any group blocked
	output hdm_cond_e monitor_condition, // Overall state
	output hdm_evt_s events, // Event pulses and stamp
	output hdm_cnt_s counters, // Cumulative counts
	output hdm_rec_s hist_rd, // Selected record
	output logic [PTR_W-1:0] hist_wptr, // Next slot written
	output logic [PTR_W-1:0] hist_fill // Valid records
);
	hdm_st_s s_q, s_d;
	logic blk_now;
	logic [CH_N-1:0][THD_W-1:0] chan_val;
	hdm_grp_out_s [2:0] grp_q;
	logic [EV_N-1:0] lvl;
	logic [EV_N-1:0] rise;
	logic [EV_N-1:0] fall;
	logic [EV_N-1:0] grant;
	logic [2:0] gidx;

	// Lowest pending event first
	function automatic logic [2:0] first_set(input logic [EV_N-1:0] v);
		logic [2:0] r;
		r = '0;
		for (int i = EV_N - 1; i >= 0; i--) begin
			if (v[i])
				r = 3'(i);
		end
		return r;
	endfunction

	// Block level is frozen between ticks; the groups see the new sample
	assign blk_now = tick ? block_in : s_q.blk; // RULE_02
	// One static selection for every channel
	assign chan_val = mag_power ? thd_pow : thd_amp; // RULE_19

	// Phase group watches three channels, residual groups one each
	for (genvar g = 0; g < 3; g++) begin : g_grp
		localparam int LO = (g == 0) ? 0 : g + 2;
		localparam int NCH = (g == 0) ? 3 : 1;
		hdm_group #(.N(NCH)) u_grp (
			.clk(clk),
			.nrst(nrst),
			.tick(tick),
			.blk(blk_now),
			.en(elem_en[g]),
			.set(pickup_set[g]),
			.delay(alarm_delay[g]),
			.val(chan_val[LO +: NCH]),
			.q(grp_q[g])
		);
		assign start_o[g] = grp_q[g].start; // RULE_12
		assign alarm_o[g] = grp_q[g].alarm;
	end
	assign blocked_o = grp_q[0].blocked | grp_q[1].blocked | grp_q[2].blocked; // RULE_12

	// Output levels and their edges
	assign lvl = {blocked_o, alarm_o, start_o};
	assign rise = lvl & ~s_q.prev;
	assign fall = ~lvl & s_q.prev;
	assign gidx = first_set(s_q.pend);
	assign grant = (|s_q.pend) ? EV_N'(1) << gidx : '0;

	// Events, counters, history; one record written per clock
	always_comb begin
		s_d = s_q;
		if (tick)
			s_d.blk = block_in; // RULE_02
		s_d.prev = lvl;
		s_d.ev.on = rise & ev_on_en; // RULE_08 RULE_09
		s_d.ev.off = fall & ev_off_en; // RULE_09
		if (|(rise | fall))
			s_d.ev.ts = time_now; // RULE_10
		// Blocked has priority since it hides any start
		if (blocked_o)
			s_d.cond = COND_BLOCKED; // RULE_01
		else if (|alarm_o)
			s_d.cond = COND_ALARM;
		else if (|start_o)
			s_d.cond = COND_START;
		else
			s_d.cond = COND_NORMAL;
		// An event in the clear cycle still counts
		s_d.cnt.start = (cnt_clr ? '0 : s_q.cnt.start) + CNT_W'(rise[0])
			+ CNT_W'(rise[1]) + CNT_W'(rise[2]); // RULE_11
		s_d.cnt.alarm = (cnt_clr ? '0 : s_q.cnt.alarm) + CNT_W'(rise[3])
			+ CNT_W'(rise[4]) + CNT_W'(rise[5]); // RULE_11
		s_d.cnt.blocked = (cnt_clr ? '0 : s_q.cnt.blocked) + CNT_W'(rise[EV_BLOCKED]);
		// Snapshot taken at the change so a queued record keeps its moment
		if (|rise) begin
			s_d.tpl_ts = time_now; // RULE_10
			s_d.tpl_ph = chan_val[2:0];
		end
		s_d.pend = (s_q.pend & ~grant) | rise; // RULE_14
		if (|grant) begin
			s_d.hist[s_q.wptr] = '{ts: s_q.tpl_ts, code: gidx, ph: s_q.tpl_ph,
				grp: setting_group}; // RULE_15
			s_d.wptr = (s_q.wptr == PTR_W'(HIST_N - 1)) ? '0 : s_q.wptr + 1'b1; // RULE_13
			if (s_q.fill != PTR_W'(HIST_N))
				s_d.fill = s_q.fill + 1'b1;
		end
		s_d.rd = (rd_idx < PTR_W'(HIST_N)) ? s_q.hist[rd_idx] : '0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign monitor_condition = s_q.cond;
	assign events = s_q.ev;
	assign counters = s_q.cnt;
	assign hist_rd = s_q.rd;
	assign hist_wptr = s_q.wptr;
	assign hist_fill = s_q.fill;

	// Checks
	property p_blk_stable;
		@(posedge clk) disable iff (!nrst) !tick |=> $stable(s_q.blk);
	endproperty
	a_blk_stable: assert property (p_blk_stable) else $error("block sample moved"); // RULE_02
	property p_cond;
		@(posedge clk) disable iff (!nrst) blocked_o |=> monitor_condition == COND_BLOCKED;
	endproperty
	a_cond: assert property (p_cond) else $error("condition not blocked"); // RULE_01
	property p_ev_on;
		@(posedge clk) disable iff (!nrst) rise[0] |=> events.on[0] == $past(ev_on_en[0]);
	endproperty
	a_ev_on: assert property (p_ev_on) else $error("start ON event wrong"); // RULE_09
	property p_ev_off;
		@(posedge clk) disable iff (!nrst) fall[3] |=> events.off[3] == $past(ev_off_en[3]);
	endproperty
	a_ev_off: assert property (p_ev_off) else $error("alarm OFF event wrong"); // RULE_08
	property p_ev_ts;
		@(posedge clk) disable iff (!nrst) |(rise | fall) |=> events.ts == $past(time_now);
	endproperty
	a_ev_ts: assert property (p_ev_ts) else $error("event stamp wrong"); // RULE_10
	property p_cnt_clr;
		@(posedge clk) disable iff (!nrst) cnt_clr && rise == '0 |=> counters.start == '0;
	endproperty
	a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared"); // RULE_11
	property p_wptr;
		@(posedge clk) disable iff (!nrst) hist_wptr < PTR_W'(HIST_N) && hist_fill <= PTR_W'(HIST_N);
	endproperty
	a_wptr: assert property (p_wptr) else $error("history pointer out of range"); // RULE_13
	property p_rec_on;
		@(posedge clk) disable iff (!nrst) $changed(hist_wptr) |-> $past(|s_q.pend);
	endproperty
	a_rec_on: assert property (p_rec_on) else $error("record without ON event"); // RULE_14

	// Condition trails the output levels by one clock
	property p_cond_idle;
		@(posedge clk) disable iff (!nrst) lvl == '0 |=> monitor_condition == COND_NORMAL;
	endproperty
	a_cond_idle: assert property (p_cond_idle) else $error("condition not normal"); // RULE_01
	property p_cond_alarm;
		@(posedge clk) disable iff (!nrst)
			!blocked_o && (|alarm_o) |=> monitor_condition == COND_ALARM;
	endproperty
	a_cond_alarm: assert property (p_cond_alarm) else $error("condition not alarm"); // RULE_01
	// Counter steps on the edge unless a clear is pending
	property p_cnt_blk;
		@(posedge clk) disable iff (!nrst)
			!cnt_clr && rise[EV_BLOCKED] |=> counters.blocked == $past(counters.blocked) + 1'b1;
	endproperty
	a_cnt_blk: assert property (p_cnt_blk) else $error("blocked count missed"); // RULE_11
	// Full history stays full; the pointer wraps to the oldest slot
	property p_fill_sat;
		@(posedge clk) disable iff (!nrst)
			hist_fill == PTR_W'(HIST_N) |=> hist_fill == PTR_W'(HIST_N);
	endproperty
	a_fill_sat: assert property (p_fill_sat) else $error("history fill dropped"); // RULE_13
	property p_wrap;
		@(posedge clk) disable iff (!nrst)
			hist_wptr == PTR_W'(HIST_N - 1) && grant != '0 |=> hist_wptr == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("history pointer did not wrap"); // RULE_13
	// An ON edge is queued at once; the lowest queued edge is written one clock later
	sequence s_on_edge;
		|rise;
	endsequence
	sequence s_slot_moved;
		##2 $changed(hist_wptr);
	endsequence
	property p_rec_write;
		@(posedge clk) disable iff (!nrst) s_on_edge |-> s_slot_moved;
	endproperty
	a_rec_write: assert property (p_rec_write) else $error("ON edge never recorded"); // RULE_14
endmodule // hdm_monitor

// >>> hdm_pkg.sv
package hdm_pkg;
	// Widths of measured values, settings and the time base
	localparam int THD_W = 14;
	localparam int DLY_W = 19;
	localparam int TS_W = 48;
	localparam int CNT_W = 16;
	localparam int GRP_W = 3;
	localparam int EV_N = 7;
	localparam int HIST_N = 12;
	localparam int PTR_W = 4;
	localparam int CH_N = 5;

	// Program cycle and delay defaults, delay counted in program cycles
	localparam int PROG_CYCLE_MS = 5;
	localparam int DELAY_DEF_MS = 10000;
	localparam logic [DLY_W-1:0] DELAY_RST = DLY_W'(DELAY_DEF_MS / PROG_CYCLE_MS);
	// Pick-up default, in 0.01 % steps
	localparam logic [THD_W-1:0] PICKUP_RST = 14'h03e8;
	// Release ratio as a fraction of the setting
	localparam logic [6:0] REL_NUM = 7'h61;
	localparam logic [6:0] REL_DEN = 7'h64;

	// Event bit positions
	localparam int EV_START0 = 0;
	localparam int EV_ALARM0 = 3;
	localparam int EV_BLOCKED = 6;

	typedef enum logic [1:0] {
		COND_NORMAL = 2'b00,
		COND_START = 2'b01,
		COND_ALARM = 2'b10,
		COND_BLOCKED = 2'b11
	} hdm_cond_e;

	typedef struct packed {
		logic start;
		logic alarm;
		logic blocked;
	} hdm_grp_out_s;

	typedef struct packed {
		logic pu;
		logic start;
		logic alarm;
		logic blocked;
		logic [DLY_W-1:0] timer;
	} hdm_grp_st_s;

	typedef struct packed {
		logic [EV_N-1:0] on;
		logic [EV_N-1:0] off;
		logic [TS_W-1:0] ts;
	} hdm_evt_s;

	typedef struct packed {
		logic [CNT_W-1:0] start;
		logic [CNT_W-1:0] alarm;
		logic [CNT_W-1:0] blocked;
	} hdm_cnt_s;

	typedef struct packed {
		logic [TS_W-1:0] ts;
		logic [2:0] code;
		logic [2:0][THD_W-1:0] ph;
		logic [GRP_W-1:0] grp;
	} hdm_rec_s;

	typedef struct packed {
		logic blk;
		logic [EV_N-1:0] prev;
		hdm_evt_s ev;
		hdm_cond_e cond;
		hdm_cnt_s cnt;
		logic [EV_N-1:0] pend;
		logic [TS_W-1:0] tpl_ts;
		logic [2:0][THD_W-1:0] tpl_ph;
		hdm_rec_s [HIST_N-1:0] hist;
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] fill;
		hdm_rec_s rd;
	} hdm_st_s;

	// Above the setting: pick-up
	function automatic logic thd_over(input logic [THD_W-1:0] v, input logic [THD_W-1:0] s);
		return v > s;
	endfunction

	// At or above 97 % of the setting: an active pick-up holds
	function automatic logic thd_keep(input logic [THD_W-1:0] v, input logic [THD_W-1:0] s);
		logic [THD_W+6:0] lhs;
		logic [THD_W+6:0] rhs;
		lhs = (THD_W+7)'(v) * (THD_W+7)'(REL_DEN);
		rhs = (THD_W+7)'(s) * (THD_W+7)'(REL_NUM);
		return lhs >= rhs;
	endfunction
endpackage
